// *** src/wdt_pkg.sv ***
// shared constants and types of the apb watchdog timer
package wdt_pkg;

   localparam int          DATA_W = 32;
   localparam int          ADDR_W = 12;

   // apb request signals of one transfer
   typedef struct packed
   {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   //////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [ADDR_W-1:0] CONTROL_OFS       = 12'h000;
   localparam logic [ADDR_W-1:0] TIMEOUT_RANGE_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] COUNT_VALUE_OFS   = 12'h008;
   localparam logic [ADDR_W-1:0] RESTART_OFS       = 12'h00C;
   localparam logic [ADDR_W-1:0] INT_CLEAR_OFS     = 12'h010;
   localparam logic [ADDR_W-1:0] EVENT_STATUS_OFS  = 12'h014;
   localparam logic [ADDR_W-1:0] EVENT_MASK_OFS    = 12'h018;

   //////////////////////////////////////////////////////////////////////////
   // field positions and widths
   localparam int          EN_BIT        = 0;
   localparam int          MODE_BIT      = 1;
   localparam int          PULSE_LSB     = 2;
   localparam int          PULSE_W       = 3;
   localparam int          TOP_LSB       = 0;
   localparam int          TOP_INIT_LSB  = 4;
   localparam int          TOP_W         = 4;
   localparam int          KEY_W         = 8;
   localparam int          EV_TIMEOUT    = 0;
   localparam int          EV_SYSRESET   = 1;
   localparam int          EV_W          = 2;

   //////////////////////////////////////////////////////////////////////////
   // values
   localparam logic [KEY_W-1:0] RESTART_KEY    = 8'h76;
   localparam int               TIMEOUT_EXP_BASE = 16;
   localparam int               PULSE_MIN_EXP  = 1;
   localparam int               PULSE_CNT_W    = 9;
   localparam logic [TOP_W-1:0] TOP_RST        = 4'h0;
   localparam logic [PULSE_W-1:0] PULSE_RST    = 3'h0;
   localparam logic [EV_W-1:0]  EV_RST         = 2'h0;

   typedef enum logic
   {
      RESP_RESET,
      RESP_INTERRUPT
   } resp_mode_t;

endpackage

// *** src/wdt_down_counter.sv ***
// loadable 32-bit down counter that stops at zero
`timescale 1ns/1ps
`default_nettype none
module wdt_down_counter
   import wdt_pkg::*;
#(
   parameter int WIDTH = 32
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadVal,
   input  wire logic             dec,
   output logic      [WIDTH-1:0] count,
   output logic                  atZero
);

   typedef struct packed
   {
      logic [WIDTH-1:0] value;
   } cnt_state_t;

   cnt_state_t state_ff;
   cnt_state_t nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      if (load)
      begin
         nxt_state.value = loadVal;
      end
      else if (dec && (state_ff.value != '0))
      begin
         nxt_state.value = state_ff.value - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign count  = state_ff.value;
   assign atZero = (state_ff.value == '0);

   a_count_step: assert property (
      @(posedge ref_clk) disable iff (reset)
      (dec && !load && !atZero) |=> (count == $past(count) - 1'b1))
      else $error("counter did not step down by one");

endmodule
`default_nettype wire

// *** src/wdt_reset_pulse.sv ***
// system reset pulse of selectable length
`timescale 1ns/1ps
`default_nettype none
module wdt_reset_pulse
   import wdt_pkg::*;
#(
   parameter int CW = PULSE_CNT_W
)
(
   input  wire logic               ref_clk,
   input  wire logic               reset,
   input  wire logic               fire,
   input  wire logic [PULSE_W-1:0] pulseSel,
   output logic                    pulse
);

   typedef struct packed
   {
      logic          active;
      logic [CW-1:0] remain;
   } pulse_state_t;

   pulse_state_t  state_ff;
   pulse_state_t  nxt_state;
   logic [CW-1:0] lenM1;

   // 2, 4 .. 256 cycles
   assign lenM1 = (CW'(1) << (32'(pulseSel) + PULSE_MIN_EXP)) - CW'(1);

   always_comb
   begin
      nxt_state = state_ff;
      if (state_ff.active)
      begin
         // a new fire or a restart cannot shorten a running pulse
         if (state_ff.remain == '0)
         begin
            nxt_state.active = 1'b0;
         end
         else
         begin
            nxt_state.remain = state_ff.remain - 1'b1;
         end
      end
      else if (fire)
      begin
         nxt_state.active = 1'b1;
         nxt_state.remain = lenM1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign pulse = state_ff.active;

   a_pulse_hold: assert property (
      @(posedge ref_clk) disable iff (reset)
      (pulse && (state_ff.remain != '0)) |=> pulse)
      else $error("reset pulse ended early");

   a_pulse_length: assert property (
      @(posedge ref_clk) disable iff (reset)
      $rose(pulse) |-> (state_ff.remain == $past(lenM1)))
      else $error("reset pulse length wrong");

   a_pulse_refire: assert property (
      @(posedge ref_clk) disable iff (reset)
      (pulse && fire && (state_ff.remain != '0))
      |=> (pulse && (state_ff.remain == $past(state_ff.remain) - 1'b1)))
      else $error("reset pulse restarted by a new fire");

endmodule
`default_nettype wire

// *** src/apb_watchdog_timer.sv ***
// apb watchdog timer with interrupt-first response and reset pulse
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module apb_watchdog_timer
   import wdt_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire apb_req_t          apbReq,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   sysReset,
   output logic                   irq
);

   //////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed
   {
      logic              dogEnable;
      resp_mode_t        responseMode;
      logic [PULSE_W-1:0] pulseSel;
      logic [TOP_W-1:0]  topSel;
      logic [TOP_W-1:0]  topInit;
      logic              firstPeriod;
      logic              enPrev;
      logic [EV_W-1:0]   evStatus;
      logic [EV_W-1:0]   evMask;
      logic              irq;
      logic [DATA_W-1:0] rdata;
      logic              slvErr;
   } wdt_state_t;

   wdt_state_t        state_ff;
   wdt_state_t        nxt_state;

   logic              setupPh;
   logic              accessPh;
   logic              wrAcc;
   logic              rdAcc;
   logic              mapped;
   logic              enRise;
   logic              restartHit;
   logic              timeoutHit;
   logic              intClearRd;
   logic              fireReset;
   logic              pendSet;
   logic              pendClr;
   logic [EV_W-1:0]   evSet;
   logic [EV_W-1:0]   evW1c;
   logic              cntLoad;
   logic              cntDec;
   logic              cntZero;
   logic [DATA_W-1:0] cntVal;
   logic [DATA_W-1:0] cntLoadVal;
   logic [DATA_W-1:0] initVal;
   logic [DATA_W-1:0] topVal;
   logic [DATA_W-1:0] curVal;

   //////////////////////////////////////////////////////////////////////////
   // apb decode

   assign setupPh  = apbReq.psel && !apbReq.penable;
   assign accessPh = apbReq.psel && apbReq.penable;
   assign wrAcc    = accessPh && apbReq.pwrite;
   assign rdAcc    = accessPh && !apbReq.pwrite;

   always_comb
   begin
      unique case (apbReq.paddr)
         CONTROL_OFS,
         TIMEOUT_RANGE_OFS,
         COUNT_VALUE_OFS,
         RESTART_OFS,
         INT_CLEAR_OFS,
         EVENT_STATUS_OFS,
         EVENT_MASK_OFS:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // timeout values

   assign initVal = DATA_W'(1) << (32'(state_ff.topInit) + TIMEOUT_EXP_BASE);
   assign topVal  = DATA_W'(1) << (32'(state_ff.topSel) + TIMEOUT_EXP_BASE);
   assign curVal  = state_ff.firstPeriod ? initVal : topVal;

   //////////////////////////////////////////////////////////////////////////
   // counter control

   assign enRise = state_ff.dogEnable && !state_ff.enPrev;

   assign restartHit = wrAcc
                     && (apbReq.paddr == RESTART_OFS)
                     && (apbReq.pwdata[KEY_W-1:0] == RESTART_KEY);

   // a restart on the zero cycle wins, so no timeout is seen
   assign timeoutHit = state_ff.dogEnable
                     && state_ff.enPrev
                     && cntZero
                     && !restartHit;

   assign cntLoad = enRise || restartHit || timeoutHit;
   assign cntDec  = state_ff.dogEnable && !cntLoad;

   always_comb
   begin
      if (enRise)
      begin
         cntLoadVal = initVal;
      end
      else if (restartHit)
      begin
         cntLoadVal = curVal;
      end
      else
      begin
         cntLoadVal = topVal;
      end
   end

   wdt_down_counter #(
      .WIDTH   (DATA_W)
   ) u_counter (
      .ref_clk (ref_clk),
      .reset   (reset),
      .load    (cntLoad),
      .loadVal (cntLoadVal),
      .dec     (cntDec),
      .count   (cntVal),
      .atZero  (cntZero)
   );

   //////////////////////////////////////////////////////////////////////////
   // timeout response

   assign fireReset = timeoutHit
                   && ((state_ff.responseMode == RESP_RESET)
                    || state_ff.evStatus[EV_TIMEOUT]);

   assign pendSet = timeoutHit
                 && (state_ff.responseMode == RESP_INTERRUPT)
                 && !state_ff.evStatus[EV_TIMEOUT];

   assign intClearRd = rdAcc && (apbReq.paddr == INT_CLEAR_OFS);

   assign pendClr = intClearRd || restartHit;

   wdt_reset_pulse #(
      .CW       (PULSE_CNT_W)
   ) u_pulse (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .fire     (fireReset),
      .pulseSel (state_ff.pulseSel),
      .pulse    (sysReset)
   );

   //////////////////////////////////////////////////////////////////////////
   // events

   always_comb
   begin
      evSet = '0;
      evSet[EV_TIMEOUT]  = pendSet;
      evSet[EV_SYSRESET] = fireReset;
      evW1c = '0;
      if (wrAcc && (apbReq.paddr == EVENT_STATUS_OFS))
      begin
         evW1c = apbReq.pwdata[EV_W-1:0];
      end
      evW1c[EV_TIMEOUT] = evW1c[EV_TIMEOUT] || pendClr;
   end

   //////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.enPrev = state_ff.dogEnable;

      if (enRise)
      begin
         nxt_state.firstPeriod = 1'b1;
      end
      else if (timeoutHit)
      begin
         nxt_state.firstPeriod = 1'b0;
      end

      // set wins over clear
      nxt_state.evStatus = evSet | (state_ff.evStatus & ~evW1c);

      if (wrAcc)
      begin
         unique case (apbReq.paddr)
            CONTROL_OFS:
            begin
               nxt_state.dogEnable    = apbReq.pwdata[EN_BIT];
               nxt_state.responseMode = resp_mode_t'(apbReq.pwdata[MODE_BIT]);
               nxt_state.pulseSel     = apbReq.pwdata[PULSE_LSB +: PULSE_W];
            end
            TIMEOUT_RANGE_OFS:
            begin
               nxt_state.topSel  = apbReq.pwdata[TOP_LSB +: TOP_W];
               nxt_state.topInit = apbReq.pwdata[TOP_INIT_LSB +: TOP_W];
            end
            EVENT_MASK_OFS:
            begin
               nxt_state.evMask = apbReq.pwdata[EV_W-1:0];
            end
            default:
            begin
            end
         endcase
      end

      nxt_state.irq = |(nxt_state.evStatus & nxt_state.evMask);

      // read data and error latched in the setup phase
      if (setupPh)
      begin
         nxt_state.slvErr = !mapped;
         nxt_state.rdata  = '0;
         if (!apbReq.pwrite)
         begin
            unique case (apbReq.paddr)
               CONTROL_OFS:
               begin
                  nxt_state.rdata[EN_BIT]               = state_ff.dogEnable;
                  nxt_state.rdata[MODE_BIT]             = state_ff.responseMode;
                  nxt_state.rdata[PULSE_LSB +: PULSE_W] = state_ff.pulseSel;
               end
               TIMEOUT_RANGE_OFS:
               begin
                  nxt_state.rdata[TOP_LSB +: TOP_W]      = state_ff.topSel;
                  nxt_state.rdata[TOP_INIT_LSB +: TOP_W] = state_ff.topInit;
               end
               COUNT_VALUE_OFS:
               begin
                  nxt_state.rdata = cntVal;
               end
               EVENT_STATUS_OFS:
               begin
                  nxt_state.rdata[EV_W-1:0] = state_ff.evStatus;
               end
               EVENT_MASK_OFS:
               begin
                  nxt_state.rdata[EV_W-1:0] = state_ff.evMask;
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff              <= '0;
         state_ff.responseMode <= RESP_RESET;
         state_ff.pulseSel     <= PULSE_RST;
         state_ff.topSel       <= TOP_RST;
         state_ff.topInit      <= TOP_RST;
         state_ff.evStatus     <= EV_RST;
         state_ff.evMask       <= EV_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata  = state_ff.rdata;
   assign pslverr = state_ff.slvErr && accessPh;
   assign pready  = 1'b1;
   assign irq     = state_ff.irq;

   //////////////////////////////////////////////////////////////////////////
   // checks

   a_enable_load: assert property (
      @(posedge ref_clk) disable iff (reset)
      enRise |=> (cntVal == $past(initVal)))
      else $error("enable did not load initial timeout");

   a_timeout_reload: assert property (
      @(posedge ref_clk) disable iff (reset)
      timeoutHit |=> (cntVal == $past(topVal)))
      else $error("timeout reload did not use select field");

   a_restart_reload: assert property (
      @(posedge ref_clk) disable iff (reset)
      (restartHit && !enRise) |=> (cntVal == $past(curVal)))
      else $error("restart did not reload the counter");

   a_bad_key: assert property (
      @(posedge ref_clk) disable iff (reset)
      (wrAcc && (apbReq.paddr == RESTART_OFS)
       && (apbReq.pwdata[KEY_W-1:0] != RESTART_KEY)
       && cntDec && !cntZero)
      |=> (cntVal == $past(cntVal) - 1'b1))
      else $error("wrong key restarted the counter");

   a_mode0_reset: assert property (
      @(posedge ref_clk) disable iff (reset)
      (timeoutHit && (state_ff.responseMode == RESP_RESET)) |=> sysReset)
      else $error("no system reset in reset mode");

   a_mode1_second: assert property (
      @(posedge ref_clk) disable iff (reset)
      (timeoutHit && (state_ff.responseMode == RESP_INTERRUPT))
      |=> ($past(state_ff.evStatus[EV_TIMEOUT]) ? sysReset
                                                : state_ff.evStatus[EV_TIMEOUT]))
      else $error("interrupt mode timeout response wrong");

   a_restart_zero: assert property (
      @(posedge ref_clk) disable iff (reset)
      (state_ff.dogEnable && state_ff.enPrev && cntZero && restartHit)
      |=> !state_ff.evStatus[EV_TIMEOUT] ##1 !sysReset)
      else $error("interrupt raised on restart at zero");

   a_clear_read: assert property (
      @(posedge ref_clk) disable iff (reset)
      (intClearRd && !timeoutHit) |=> !state_ff.evStatus[EV_TIMEOUT])
      else $error("clear read left interrupt pending");

   a_clear_restart: assert property (
      @(posedge ref_clk) disable iff (reset)
      restartHit |=> !state_ff.evStatus[EV_TIMEOUT])
      else $error("restart left interrupt pending");

   a_irq_level: assert property (
      @(posedge ref_clk) disable iff (reset)
      ##1 (irq == |($past(nxt_state.evStatus) & $past(nxt_state.evMask))))
      else $error("interrupt output does not follow status and mask");

endmodule
`default_nettype wire

// *** bench/wdt_reset_ctrl_model.sv ***
// system reset controller model: watches and measures reset pulses
`timescale 1ns/1ps
`default_nettype none
module wdt_reset_ctrl_model
(
   input  wire logic ref_clk,
   input  wire logic sysReset,
   output var  int   pulseLen,
   output var  int   pulseCnt
);
   int runLen;

   initial
   begin
      runLen = 0;
      pulseLen = 0;
      pulseCnt = 0;
   end

   //////////////////////////////////////////////////////////////////////////
   // count the edges at which reset is seen high, report on release
   always @(posedge ref_clk)
   begin
      if (sysReset === 1'b1)
         runLen = runLen + 1;
      else if (runLen != 0)
      begin
         pulseLen = runLen;
         pulseCnt = pulseCnt + 1;
         runLen = 0;
      end
   end
endmodule
`default_nettype wire

// *** bench/apb_watchdog_timer_tb.sv ***
// self-checking bench of the apb watchdog timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module apb_watchdog_timer_tb
   import wdt_pkg::*;
;
   logic              ref_clk;
   logic              reset;
   apb_req_t          apbReq;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              sysReset;
   logic              irq;
   int                pulseLen;
   int                pulseCnt;
   int                nFail;
   int                nTests;
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] c1;
   logic [DATA_W-1:0] c2;
   logic              err;
   apb_req_t          apbReqM1;
   logic              sysResetM1;
   logic              irqM1;

   apb_watchdog_timer dut
   (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .apbReq   (apbReq),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .sysReset (sysReset),
      .irq      (irq)
   );

   wdt_reset_ctrl_model rstCtrl
   (
      .ref_clk  (ref_clk),
      .sysReset (sysReset),
      .pulseLen (pulseLen),
      .pulseCnt (pulseCnt)
   );

   // second copy in interrupt mode, timeout mask bit forced on
   always_comb
   begin
      apbReqM1 = apbReq;
      if (apbReq.paddr == CONTROL_OFS)
      begin
         apbReqM1.pwdata[MODE_BIT] = 1'b1;
      end
      if (apbReq.paddr == EVENT_MASK_OFS)
      begin
         apbReqM1.pwdata[EV_TIMEOUT] = 1'b1;
      end
   end

   apb_watchdog_timer dutM1
   (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .apbReq   (apbReqM1),
      .prdata   (),
      .pready   (),
      .pslverr  (),
      .sysReset (sysResetM1),
      .irq      (irqM1)
   );

   always #4 ref_clk = ~ref_clk;

   //////////////////////////////////////////////////////////////////////////
   // one apb transfer: setup, access held until pready
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      begin
         @(posedge ref_clk);
         apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
         @(posedge ref_clk);
         apbReq.penable <= 1'b1;
         @(posedge ref_clk);
         while (pready !== 1'b1)
         begin
            @(posedge ref_clk);
         end
         rd = prdata;
         err = pslverr;
         apbReq.psel <= 1'b0;
         apbReq.penable <= 1'b0;
      end
   endtask

   task automatic completeRun();
      $display("checks %0d, mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge ref_clk);
      nFail++;
      completeRun();
   end

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      int k;
      logic [ADDR_W-1:0] ofs [6];
      ofs = '{CONTROL_OFS, TIMEOUT_RANGE_OFS, COUNT_VALUE_OFS,
              INT_CLEAR_OFS, EVENT_STATUS_OFS, EVENT_MASK_OFS};
      ref_clk = 1'b0;
      reset = 1'b1;
      apbReq = '0;
      nFail = 0;
      nTests = 0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (ofs[i])
      begin
         apb(1'b0, ofs[i], 32'h0);
         `CHK(rd, 32'h0)
         `CHK(err, 1'b0)
      end
      apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h01C, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // mode reset, longest pulse, then timeout, then enable
      apb(1'b1, CONTROL_OFS, 32'h0000_001C);
      apb(1'b1, TIMEOUT_RANGE_OFS, 32'h0000_0001);
      apb(1'b1, CONTROL_OFS, 32'h0000_001D);
      apb(1'b0, CONTROL_OFS, 32'h0);
      `CHK(rd, 32'h0000_001D)
      apb(1'b0, COUNT_VALUE_OFS, 32'h0);
      c1 = rd;
      `CHK(c1 <= 32'h0001_0000 && c1 > 32'h0000_FF00, 1'b1)
      apb(1'b0, COUNT_VALUE_OFS, 32'h0);
      `CHK(rd < c1, 1'b1)
      repeat (200) @(posedge ref_clk);
      apb(1'b1, RESTART_OFS, 32'h0000_0075);
      apb(1'b0, COUNT_VALUE_OFS, 32'h0);
      c2 = rd;
      `CHK(c2 < c1 - 32'd200, 1'b1)
      apb(1'b1, RESTART_OFS, {24'h0, RESTART_KEY});
      apb(1'b0, COUNT_VALUE_OFS, 32'h0);
      `CHK(rd > c2 + 32'd150 && rd <= 32'h0001_0000, 1'b1)
      apb(1'b1, EVENT_MASK_OFS, 32'h0000_0002);
      k = 0;
      while (sysReset !== 1'b1 && k < 70000)
      begin
         k++;
         @(posedge ref_clk);
      end
      `CHK(sysReset, 1'b1)
      `CHK(irqM1, 1'b1)
      `CHK(sysResetM1, 1'b0)
      apb(1'b0, INT_CLEAR_OFS, 32'h0);
      @(posedge ref_clk);
      #1;
      `CHK(irqM1, 1'b0)
      apb(1'b1, RESTART_OFS, {24'h0, RESTART_KEY});
      k = 0;
      while (sysReset !== 1'b0 && k < 400)
      begin
         k++;
         @(posedge ref_clk);
      end
      @(posedge ref_clk);
      `CHK(pulseCnt, 1)
      `CHK(pulseLen, 32'd2 << 7)
      apb(1'b0, COUNT_VALUE_OFS, 32'h0);
      `CHK(rd > 32'h0001_0000 && rd <= 32'h0002_0000, 1'b1)
      apb(1'b0, EVENT_STATUS_OFS, 32'h0);
      `CHK(rd[EV_SYSRESET], 1'b1)
      `CHK(irq, 1'b1)
      apb(1'b1, EVENT_MASK_OFS, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(irq, 1'b0)
      apb(1'b1, EVENT_MASK_OFS, 32'h0000_0002);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(irq, 1'b1)
      apb(1'b1, EVENT_STATUS_OFS, 32'h0000_0002);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(irq, 1'b0)
      apb(1'b0, EVENT_STATUS_OFS, 32'h0);
      `CHK(rd[EV_SYSRESET], 1'b0)
      completeRun();
   end
endmodule
`default_nettype wire
